// >>> hdl/spc_pkg.sv
// Purpose: shared constants and types of the serial port control block
// Assumes: register index map seen as Avalon word addresses
// Notes:   byte address of each register is four times its index
package spc_pkg;
  // register indices (word addresses)
  localparam logic [7:0] IDX_SERIAL_CONTROL_REGISTER = 8'h98;  // serial_control_register
  localparam logic [7:0] IDX_SERIAL_DATA_BUFFER = 8'h99;  // serial_data_buffer
  localparam logic [7:0] IDX_PWR  = 8'h9A;  // power_control_register
  localparam logic [7:0] IDX_BAUD = 8'h9B;  // variable rate divisor
  // control register bit positions
  localparam int SC_MODE0 = 7;  // mode_bit0_or_frame_err
  localparam int SC_MODE1 = 6;  // mode_select_bit1
  localparam int SC_MPS   = 5;  // multiproc_select
  localparam int SC_REN   = 4;  // receive enable
  localparam int SC_TB8   = 3;  // transmit_ninth_bit
  localparam int SC_RB8   = 2;  // receive_ninth_bit
  localparam int SC_TI    = 1;  // transmit_done_flag
  localparam int SC_RI    = 0;  // receive_done_flag
  // power control bit positions
  localparam int PWR_DBL  = 7;  // mode 2 rate doubler
  localparam int PWR_FEV  = 6;  // frame_err_view_select
  // reset values
  localparam logic [7:0] SERIAL_CONTROL_REGISTER_RST = 8'h00;
  localparam logic [7:0] PWR_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  // clock division figures
  localparam int M0_DIV_SLOW = 12;  // mode 0, multiproc_select 0
  localparam int M0_DIV_FAST = 4;   // mode 0, multiproc_select 1
  localparam int M2_DIV_SLOW = 64;  // mode 2, doubler off
  localparam int M2_DIV_FAST = 32;  // mode 2, doubler on
  localparam int OVERSAMPLE  = 16;  // ticks per async bit
  localparam logic [3:0] TICK_MID  = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hF;
  // serial operating modes, code is {bit0, bit1}
  typedef enum logic [1:0] {
    SPC_MODE0 = 2'b00,
    SPC_MODE1 = 2'b01,
    SPC_MODE2 = 2'b10,
    SPC_MODE3 = 2'b11
  } spc_mode_t;
  // receiver states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } spc_rx_st_t;
endpackage

// >>> hdl/spc_rx_if.sv
// Purpose: link between control logic and asynchronous receiver
// Assumes: one clock domain
// Notes:   done is a one-cycle pulse with data, ninth and stop valid
`timescale 1ns/10ps
interface spc_rx_if;
  logic       en;     // reception allowed
  logic       nine;   // frame carries a ninth bit
  logic       tick;   // oversample tick
  logic       done;   // frame received
  logic [7:0] data;   // received byte
  logic       ninth;  // received ninth bit
  logic       stop;   // sampled stop bit
  modport ctl (output en, nine, tick, input done, data, ninth, stop);
  modport rx  (input en, nine, tick, output done, data, ninth, stop);
endinterface

// >>> hdl/spc_rate.sv
// Purpose: rate tick generator for the serial port
// Assumes: mode 0 tick is a half bit, other modes a 1/16 bit
// Notes:   free running, so the first mode 0 half bit may be short
`timescale 1ns/10ps
module spc_rate (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // rate selection
  input  wire spc_pkg::spc_mode_t i_mode,
  input  wire logic              i_mps,
  input  wire logic              i_dbl,
  input  wire logic [7:0]        i_div,
  // tick out
  output logic                   o_tick
);
  import spc_pkg::*;
  localparam logic [7:0] M0_SLOW = 8'((M0_DIV_SLOW / 2) - 1);
  localparam logic [7:0] M0_FAST = 8'((M0_DIV_FAST / 2) - 1);
  localparam logic [7:0] M2_SLOW = 8'((M2_DIV_SLOW / OVERSAMPLE) - 1);
  localparam logic [7:0] M2_FAST = 8'((M2_DIV_FAST / OVERSAMPLE) - 1);
  logic [7:0] cnt_q;  // divider count
  logic [7:0] lim;    // terminal count for the mode
  // pick the terminal count
  always_comb begin
    unique case (i_mode)
      SPC_MODE0: lim = i_mps ? M0_FAST : M0_SLOW;
      SPC_MODE2: lim = i_dbl ? M2_FAST : M2_SLOW;
      SPC_MODE1,
      SPC_MODE3: lim = i_div;
    endcase
  end
  // divider
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_q  <= 8'h00;
      o_tick <= 1'b0;
    end else if (cnt_q >= lim) begin
      cnt_q  <= 8'h00;
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 8'h01;
      o_tick <= 1'b0;
    end
  end
endmodule

// >>> hdl/spc_rx.sv
// Purpose: asynchronous receiver for modes 1, 2 and 3
// Assumes: line input synchronous to the clock
// Notes:   stop sampled mid bit, done raised there
`timescale 1ns/10ps
module spc_rx (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  // line
  input  wire logic i_rxd,
  // control side
  spc_rx_if.rx      rx
);
  import spc_pkg::*;
  spc_rx_st_t st_q;   // receiver state
  logic [3:0] tc_q;   // tick count in bit
  logic [3:0] bn_q;   // bits shifted so far
  logic [8:0] sh_q;   // shift register, lsb first
  // frame walk
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_q     <= RX_IDLE;
      tc_q     <= 4'h0;
      bn_q     <= 4'h0;
      sh_q     <= 9'h000;
      rx.done  <= 1'b0;
      rx.data  <= 8'h00;
      rx.ninth <= 1'b0;
      rx.stop  <= 1'b0;
    end else begin
      rx.done <= 1'b0;
      unique case (st_q)
        RX_IDLE: begin
          tc_q <= 4'h0;
          if (rx.en && !i_rxd) begin
            st_q <= RX_START;
          end
        end
        RX_START: if (rx.tick) begin
          tc_q <= tc_q + 4'h1;
          if (tc_q == TICK_MID) begin
            // a glitch shorter than half a bit is dropped
            st_q <= i_rxd ? RX_IDLE : RX_DATA;
            tc_q <= 4'h0;
            bn_q <= 4'h0;
          end
        end
        RX_DATA: if (rx.tick) begin
          tc_q <= tc_q + 4'h1;
          if (tc_q == TICK_LAST) begin
            sh_q <= {i_rxd, sh_q[8:1]};
            bn_q <= bn_q + 4'h1;
            if (bn_q == (rx.nine ? 4'h8 : 4'h7)) begin
              st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: if (rx.tick) begin
          tc_q <= tc_q + 4'h1;
          if (tc_q == TICK_LAST) begin
            rx.done  <= 1'b1;
            rx.stop  <= i_rxd;
            rx.data  <= rx.nine ? sh_q[7:0] : sh_q[8:1];
            rx.ninth <= rx.nine & sh_q[8];
            st_q     <= RX_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// >>> hdl/spc_top.sv
// Purpose: serial port control, status and shifting behind Avalon-MM
// Assumes: registers at word addresses equal to their indices
// Notes:   one transfer engine serves transmit and mode 0 receive
//
// Summary of operation
// - bit 7 is mode bit or frame error
// - bad stop bit sets sticky frame error in error view
// - bit 6 with bit 7 picks mode
// - modes 2/3 multiproc drops ninth-bit-zero frames
// - mode 1 multiproc needs valid stop bit
// - mode 0 clock divides by 12 or 4
// - receive enable bit gates reception
// - modes 2/3 send software ninth bit
// - ninth bit field captures ninth or stop
// - transmit done at bit 8 end or stop
// - receive done at bit 8 or mid stop
// - four modes with their frame lengths
// - data buffer reads receive, writes transmit
`timescale 1ns/10ps
module spc_top (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // avalon-mm slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // serial pins
  input  wire logic        i_rxd,
  output logic             o_rxd,
  output logic             o_rxd_oe,
  output logic             o_txd
);
  import spc_pkg::*;

  // transfer engine states
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_TX   = 2'b01,
    ENG_M0TX = 2'b10,
    ENG_M0RX = 2'b11
  } spc_eng_st_t;

  // control register fields
  logic        sm0_q;   // mode bit 0
  logic        sm1_q;   // mode bit 1
  logic        mps_q;   // multiproc_select
  logic        ren_q;   // receive enable
  logic        tb8_q;   // transmit_ninth_bit
  logic        rb8_q;   // receive_ninth_bit
  logic        ti_q;    // transmit_done_flag
  logic        ri_q;    // receive_done_flag
  logic        fe_q;    // frame error flag
  // power control fields
  logic        fev_q;   // frame_err_view_select
  logic        dbl_q;   // mode 2 rate doubler
  // other registers
  logic [7:0]  baud_q;  // variable rate divisor
  logic [7:0]  rbuf_q;  // receive side of the data buffer

  // bus handshake
  logic        acc;     // request completes at this edge
  logic        wr_acc;  // write completes, low lane enabled
  logic        wr_serial_control_register; // control register write
  logic        wr_serial_data_buffer; // data buffer write
  logic [7:0]  wd;      // low byte of write data
  logic [7:0]  serial_control_register_rd; // control register read view

  // transfer engine
  spc_eng_st_t st_q;    // engine state
  logic [10:0] sh_q;    // shift register
  logic [3:0]  tc_q;    // tick count in bit
  logic [3:0]  bn_q;    // bit number
  logic [3:0]  last;    // index of stop bit
  logic        ph_q;    // mode 0 clock phase, 1 is high half
  logic        ti_set_q;  // engine asks to set transmit done
  logic        m0_done_q; // engine finished a mode 0 receive

  // shared signals
  spc_mode_t   mode;    // current operating mode
  logic        tick;    // rate tick
  spc_rx_if    rxi ();  // async receiver link
  logic        rx_ok;   // async frame passes multiproc filter

  // mode decode
  assign mode = spc_mode_t'({sm0_q, sm1_q});

  // rate generator
  spc_rate u_rate (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_mode    (mode),
    .i_mps     (mps_q),
    .i_dbl     (dbl_q),
    .i_div     (baud_q),
    .o_tick    (tick)
  );

  // asynchronous receiver, idle in mode 0
  assign rxi.en   = ren_q && (mode != SPC_MODE0);
  assign rxi.nine = sm0_q;  // modes 2 and 3 carry a ninth bit
  assign rxi.tick = tick;

  spc_rx u_rx (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_rxd     (i_rxd),
    .rx        (rxi)
  );

  // bus decode
  assign acc     = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  assign wr_acc  = acc && i_avs_write && i_avs_byteenable[0];
  assign wd      = i_avs_writedata[7:0];
  assign wr_serial_control_register = wr_acc && (i_avs_address == IDX_SERIAL_CONTROL_REGISTER);
  assign wr_serial_data_buffer = wr_acc && (i_avs_address == IDX_SERIAL_DATA_BUFFER);

  // bit 7 shows the error flag or the mode bit
  assign serial_control_register_rd = {fev_q ? fe_q : sm0_q,
                    sm1_q, mps_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};

  // multiproc filter for a finished async frame
  always_comb begin
    if (mode == SPC_MODE1) begin
      rx_ok = !mps_q || rxi.stop;
    end else begin
      rx_ok = !mps_q || rxi.ninth;
    end
  end

  // stop bit index: 10 bit frame in mode 1, 11 bit otherwise
  assign last = (mode == SPC_MODE1) ? 4'h9 : 4'hA;

  // waitrequest: high on the first cycle of a request, low on the second
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // read data, latched as the request is first seen
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && o_avs_waitrequest) begin
      unique case (i_avs_address)
        IDX_SERIAL_CONTROL_REGISTER: o_avs_readdata <= {24'h000000, serial_control_register_rd};
        IDX_SERIAL_DATA_BUFFER: o_avs_readdata <= {24'h000000, rbuf_q};
        IDX_PWR:  o_avs_readdata <= {24'h000000, dbl_q, fev_q, 6'h00};
        IDX_BAUD: o_avs_readdata <= {24'h000000, baud_q};
        default:  o_avs_readdata <= 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end

  // mode and software-only control fields
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sm0_q <= SERIAL_CONTROL_REGISTER_RST[SC_MODE0];
      sm1_q <= SERIAL_CONTROL_REGISTER_RST[SC_MODE1];
      mps_q <= SERIAL_CONTROL_REGISTER_RST[SC_MPS];
      ren_q <= SERIAL_CONTROL_REGISTER_RST[SC_REN];
      tb8_q <= SERIAL_CONTROL_REGISTER_RST[SC_TB8];
    end else if (wr_serial_control_register) begin
      if (!fev_q) begin
        sm0_q <= wd[SC_MODE0];
      end
      sm1_q <= wd[SC_MODE1];
      mps_q <= wd[SC_MPS];
      ren_q <= wd[SC_REN];
      tb8_q <= wd[SC_TB8];
    end
  end

  // power control and divisor
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fev_q  <= PWR_RST[PWR_FEV];
      dbl_q  <= PWR_RST[PWR_DBL];
      baud_q <= BAUD_RST;
    end else begin
      if (wr_acc && (i_avs_address == IDX_PWR)) begin
        fev_q <= wd[PWR_FEV];
        dbl_q <= wd[PWR_DBL];
      end
      if (wr_acc && (i_avs_address == IDX_BAUD)) begin
        baud_q <= wd;
      end
    end
  end

  // transmit done flag; a hardware set beats a same-cycle software clear
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ti_q <= SERIAL_CONTROL_REGISTER_RST[SC_TI];
    end else if (ti_set_q) begin
      ti_q <= 1'b1;
    end else if (wr_serial_control_register) begin
      ti_q <= wd[SC_TI];
    end
  end

  // frame error flag, cleared only by a write in error view
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fe_q <= 1'b0;
    end else if (rxi.done && !rxi.stop && fev_q) begin
      fe_q <= 1'b1;
    end else if (wr_serial_control_register && fev_q) begin
      fe_q <= wd[SC_MODE0];
    end
  end

  // receive done flag, ninth bit and receive buffer
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ri_q   <= SERIAL_CONTROL_REGISTER_RST[SC_RI];
      rb8_q  <= SERIAL_CONTROL_REGISTER_RST[SC_RB8];
      rbuf_q <= 8'h00;
    end else begin
      // software first, so a hardware set below wins
      if (wr_serial_control_register) begin
        ri_q  <= wd[SC_RI];
        rb8_q <= wd[SC_RB8];
      end
      if (m0_done_q) begin
        // mode 0: ninth bit field left alone
        rbuf_q <= sh_q[7:0];
        ri_q   <= 1'b1;
      end else if (rxi.done && !ri_q && rx_ok) begin
        // an unread frame is kept; the new one is lost
        rbuf_q <= rxi.data;
        ri_q   <= 1'b1;
        if (mode == SPC_MODE1) begin
          rb8_q <= rxi.stop;
        end else begin
          rb8_q <= rxi.ninth;
        end
      end
    end
  end

  // transfer engine: async transmit and both mode 0 directions
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_q      <= ENG_IDLE;
      sh_q      <= 11'h7FF;
      tc_q      <= 4'h0;
      bn_q      <= 4'h0;
      ph_q      <= 1'b0;
      o_txd     <= 1'b1;
      o_rxd     <= 1'b1;
      o_rxd_oe  <= 1'b0;
      ti_set_q  <= 1'b0;
      m0_done_q <= 1'b0;
    end else begin
      ti_set_q  <= 1'b0;
      m0_done_q <= 1'b0;
      unique case (st_q)
        ENG_IDLE: begin
          tc_q     <= 4'h0;
          bn_q     <= 4'h0;
          ph_q     <= 1'b0;
          o_txd    <= 1'b1;
          o_rxd_oe <= 1'b0;
          if (wr_serial_data_buffer && (mode == SPC_MODE0)) begin
            // clock low first half, data set up on the data pin
            sh_q     <= {3'b111, wd};
            o_rxd    <= wd[0];
            o_rxd_oe <= 1'b1;
            o_txd    <= 1'b0;
            st_q     <= ENG_M0TX;
          end else if (wr_serial_data_buffer) begin
            // start, eight data bits, ninth or stop, stop
            sh_q  <= {1'b1, sm0_q ? tb8_q : 1'b1, wd, 1'b0};
            o_txd <= 1'b0;
            st_q  <= ENG_TX;
          end else if ((mode == SPC_MODE0) && ren_q && !ri_q && !m0_done_q) begin
            // mode 0 receive waits for software to clear the receive done flag
            o_txd <= 1'b0;
            st_q  <= ENG_M0RX;
          end
        end
        ENG_TX: if (tick) begin
          tc_q <= tc_q + 4'h1;
          if (tc_q == TICK_LAST) begin
            bn_q <= bn_q + 4'h1;
            sh_q <= {1'b1, sh_q[10:1]};
            if (bn_q == last) begin
              o_txd <= 1'b1;
              st_q  <= ENG_IDLE;
            end else begin
              o_txd <= sh_q[1];
              if ((bn_q + 4'h1) == last) begin
                ti_set_q <= 1'b1;
              end
            end
          end
        end
        ENG_M0TX,
        ENG_M0RX: if (tick) begin
          ph_q <= !ph_q;
          if (!ph_q) begin
            // rising clock: receiver samples the data pin
            o_txd <= 1'b1;
            if (st_q == ENG_M0RX) begin
              sh_q[7:0] <= {i_rxd, sh_q[7:1]};
            end
          end else if (bn_q == 4'h7) begin
            // end of the eighth bit time
            o_txd    <= 1'b1;
            o_rxd    <= 1'b1;
            o_rxd_oe <= 1'b0;
            st_q     <= ENG_IDLE;
            if (st_q == ENG_M0TX) begin
              ti_set_q <= 1'b1;
            end else begin
              m0_done_q <= 1'b1;
            end
          end else begin
            o_txd <= 1'b0;
            bn_q  <= bn_q + 4'h1;
            if (st_q == ENG_M0TX) begin
              sh_q  <= {1'b1, sh_q[10:1]};
              o_rxd <= sh_q[1];
            end
          end
        end
      endcase
    end
  end

endmodule

// >>> dv/spc_top_assertions.sv
// Purpose: port-level checks of the serial port control block
// Assumes: one clock, synchronous active high reset
// Notes:   sees only the top ports, attached by bind below
`timescale 1ns/10ps
module spc_chk
  import spc_pkg::*;
(
  // clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  // register bus
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  // serial pins
  input wire logic        i_rxd,
  input wire logic        o_rxd,
  input wire logic        o_rxd_oe,
  input wire logic        o_txd
);
  int unsigned low_q;  // low cycles of the shift clock so far
  logic [7:0]  div_q;  // last accepted divisor write
  logic        done;   // a bus transfer completes now
  assign done = !o_avs_waitrequest;
  // count low time only while mode 0 drives, so async bits never saturate it
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || o_txd || !o_rxd_oe) begin
      low_q <= 0;
    end else begin
      low_q <= low_q + 1;
    end
  end
  // shadow of the divisor, updated at the completing edge only
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      div_q <= BAUD_RST;
    end else if (done && i_avs_write && i_avs_byteenable[0] && i_avs_address == IDX_BAUD) begin
      div_q <= i_avs_writedata[7:0];
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  chk_wait_drop: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered next cycle");
  chk_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  chk_rd_upper: assert property (done && i_avs_read |-> o_avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_unmapped_zero: assert property (done && i_avs_read && (i_avs_address < IDX_SERIAL_CONTROL_REGISTER || i_avs_address > IDX_BAUD)
    |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_div_read: assert property (done && i_avs_read && i_avs_address == IDX_BAUD
    |-> o_avs_readdata[7:0] == div_q)
    else $error("divisor readback wrong");
  chk_rxd_idle: assert property (!o_rxd_oe |-> o_rxd)
    else $error("data pin not idle high");
  chk_m0_half: assert property (o_rxd_oe && !o_txd |-> low_q < M0_DIV_SLOW / 2)
    else $error("mode 0 clock low too long");
  chk_rst_outs: assert property (disable iff (1'b0) i_rst |=> o_txd && o_rxd && !o_rxd_oe && o_avs_waitrequest)
    else $error("outputs not at rest after reset");
  cov_m0_frame: cover property ($rose(o_rxd_oe));
  cov_async_start: cover property ($fell(o_txd) && !o_rxd_oe);
  cov_unmapped: cover property (done && i_avs_read && i_avs_address < IDX_SERIAL_CONTROL_REGISTER);
endmodule
bind spc_top spc_chk u_chk (.i_sys_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_rxd, .o_rxd, .o_rxd_oe, .o_txd);

// >>> dv/spc_peer.sv
// Purpose: far-side serial device model
// Assumes: async line idles at mark level, lsb first
// Notes:   mode 0 capture samples data at each rising shift clock
`timescale 1ns/10ps
module spc_peer (
  // clock
  input  wire logic i_sys_clk,
  // lines from the block
  input  wire logic i_txd,
  input  wire logic i_dat,
  input  wire logic i_oe,
  // line to the block
  output logic      o_rxd
);
  logic [7:0] m0_byte;  // last mode 0 byte seen
  int         m0_low;   // length of last full low half
  int         cnt;      // running low half length
  logic       prev;     // shift clock one cycle ago
  initial begin
    o_rxd = 1'b1;
    prev = 1'b1;
    cnt = 0;
    m0_low = 0;
    m0_byte = 8'h00;
  end
  // latest low half wins, since the first one may be cut short
  always @(posedge i_sys_clk) begin
    prev <= i_txd;
    if (i_oe && !i_txd) begin
      cnt <= cnt + 1;
    end
    if (i_oe && i_txd && !prev) begin
      m0_byte <= {i_dat, m0_byte[7:1]};
      m0_low <= cnt;
      cnt <= 0;
    end
  end
  // send start bit then n bits, each bc clocks long
  task automatic send(input logic [10:0] b, input int n, input int bc);
    o_rxd <= 1'b0;
    repeat (bc) @(posedge i_sys_clk);
    for (int i = 0; i < n; i++) begin
      o_rxd <= b[i];
      repeat (bc) @(posedge i_sys_clk);
    end
    o_rxd <= 1'b1;
  endtask
  // catch an async frame; unknown bits if no start bit shows
  task automatic grab(input int n, input int bc, output logic [10:0] v);
    int k;
    v = 11'bx;
    for (k = 0; k < 400 && i_txd; k++) @(posedge i_sys_clk);
    if (k < 400) begin
      repeat (bc / 2) @(posedge i_sys_clk);
      for (int i = 0; i < n; i++) begin
        repeat (bc) @(posedge i_sys_clk);
        v[i] = i_txd;
      end
      // let the frame end, so a following mode change cannot stretch it
      repeat (bc / 2 + 2) @(posedge i_sys_clk);
    end
  endtask
  // mode 0 receive: present each bit before its rising shift clock
  task automatic feed(input logic [7:0] b);
    o_rxd <= b[0];
    for (int k = 0; k < 50 && i_txd; k++) @(posedge i_sys_clk);
    for (int i = 0; i < 8; i++) begin
      o_rxd <= b[i];
      for (int k = 0; k < 50 && !i_txd; k++) @(posedge i_sys_clk);
      for (int k = 0; k < 50 && i_txd; k++) @(posedge i_sys_clk);
    end
    o_rxd <= 1'b1;
  endtask
endmodule

// >>> dv/test_serial_port_control.sv
// Purpose: self-checking bench of the serial port control block
// Assumes: divisor 0, so a mode 1 or mode 3 async bit is 16 clocks
// Notes:   random bytes from a fixed seed
`timescale 1ns/10ps
module test_serial_port_control;
  import spc_pkg::*;
  logic        i_sys_clk;
  logic        i_rst;
  logic [7:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0]  i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic        rxd, m0_dat, m0_oe, txd;
  int          n_mismatch, checks_done, seed;
  logic [31:0] q;
  logic [10:0] v;
  logic [7:0]  d, s;
  logic [15:0] rx_tab [6] = '{16'h5010, 16'h7000, 16'h5040, 16'hF010, 16'hF011, 16'hD010};
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  spc_top DUT (.i_sys_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_rxd(rxd), .o_rxd(m0_dat),
    .o_rxd_oe(m0_oe), .o_txd(txd));
  spc_peer u_peer (.i_sys_clk, .i_txd(txd), .i_dat(m0_dat), .i_oe(m0_oe), .o_rxd(rxd));
  task end_of_test;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] dt, input logic [3:0] be);
    int k;
    @(posedge i_sys_clk);
    i_avs_address <= a;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_writedata <= {24'h0, dt};
    i_avs_byteenable <= be;
    for (k = 0; k < 50; k++) begin
      @(posedge i_sys_clk);
      if (o_avs_waitrequest === 1'b0) break;
    end
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (k == 50) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] dt);
    bus(1'b1, a, dt, 4'h1);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    check(q, {24'h0, e});
  endtask
  // control value after a frame: flag only when multiproc allows
  function automatic logic [7:0] exp_rx(logic [7:0] c, logic fev, logic stp, logic nin);
    logic ok;
    logic r8;
    r8 = c[7] ? nin : stp;
    ok = !c[5] || r8;
    return {c[7] | (fev && !stp), c[6:3], r8, c[1], ok};
  endfunction
  initial begin
    repeat (100000) @(posedge i_sys_clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {i_avs_address, i_avs_read, i_avs_write, i_avs_writedata, i_avs_byteenable} = '0;
    n_mismatch = 0;
    checks_done = 0;
    seed = 47718;
    i_rst = 1'b1;
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rdc(IDX_SERIAL_CONTROL_REGISTER, SERIAL_CONTROL_REGISTER_RST);
    rdc(IDX_PWR, PWR_RST);
    rdc(8'h97, 8'h00);
    check({30'h0, txd, m0_oe}, 32'h2);
    for (int i = 0; i < 6; i++) begin
      s = 8'h40 | (8'h3F & 8'($random(seed)));
      d = 8'($random(seed));
      wr(IDX_SERIAL_CONTROL_REGISTER, s);
      rdc(IDX_SERIAL_CONTROL_REGISTER, s);
      wr(IDX_BAUD, d);
      rdc(IDX_BAUD, d);
    end
    bus(1'b1, IDX_SERIAL_CONTROL_REGISTER, 8'hFF, 4'h0);
    rdc(IDX_SERIAL_CONTROL_REGISTER, s);
    wr(8'h97, 8'hFF);
    rdc(8'h97, 8'h00);
    wr(IDX_BAUD, 8'h00);
    wr(IDX_SERIAL_CONTROL_REGISTER, 8'h40);
    d = 8'($random(seed));
    wr(IDX_SERIAL_DATA_BUFFER, d);
    wr(IDX_SERIAL_DATA_BUFFER, ~d);
    u_peer.grab(9, 16, v);
    check(v[8:0], {1'b1, d});
    rdc(IDX_SERIAL_CONTROL_REGISTER, 8'h42);
    wr(IDX_SERIAL_CONTROL_REGISTER, 8'hC8);
    wr(IDX_SERIAL_DATA_BUFFER, d);
    u_peer.grab(10, 16, v);
    check(v[9:0], {2'b11, d});
    rdc(IDX_SERIAL_CONTROL_REGISTER, 8'hCA);
    foreach (rx_tab[i]) begin
      s = rx_tab[i][15:8];
      d = 8'($random(seed));
      wr(IDX_PWR, rx_tab[i][7:0] & 8'h40);
      wr(IDX_SERIAL_CONTROL_REGISTER, s);
      u_peer.send(s[7] ? {1'b1, rx_tab[i][4], rx_tab[i][0], d} : {2'b11, rx_tab[i][4], d}, s[7] ? 10 : 9, 16);
      rdc(IDX_SERIAL_CONTROL_REGISTER, exp_rx(s, rx_tab[i][6], rx_tab[i][4], rx_tab[i][0]));
      if (exp_rx(s, 1'b0, rx_tab[i][4], rx_tab[i][0]) & 8'h01) begin
        rdc(IDX_SERIAL_DATA_BUFFER, d);
      end
      if (rx_tab[i][6]) begin
        wr(IDX_SERIAL_CONTROL_REGISTER, s);
        rdc(IDX_SERIAL_CONTROL_REGISTER, s);
      end
    end
    for (int m = 0; m < 2; m++) begin
      s = m ? 8'h20 : 8'h00;
      d = 8'($random(seed));
      wr(IDX_SERIAL_CONTROL_REGISTER, s);
      wr(IDX_SERIAL_DATA_BUFFER, d);
      q = '0;
      for (int k = 0; k < 100 && !q[1]; k++) bus(1'b0, IDX_SERIAL_CONTROL_REGISTER, 8'h00, 4'hF);
      check(q, {24'h0, s | 8'h02});
      check({24'h0, u_peer.m0_byte}, {24'h0, d});
      check(32'(u_peer.m0_low), m ? 32'(M0_DIV_FAST / 2) : 32'(M0_DIV_SLOW / 2));
    end
    // mode 0 receive of one byte, then the flag holds further shifting off
    d = 8'($random(seed));
    wr(IDX_SERIAL_CONTROL_REGISTER, 8'h10);
    u_peer.feed(d);
    rdc(IDX_SERIAL_CONTROL_REGISTER, 8'h11);
    rdc(IDX_SERIAL_DATA_BUFFER, d);
    // mode 2 transmit with the doubler on: 32 clocks a bit
    wr(IDX_PWR, 8'h80);
    wr(IDX_SERIAL_CONTROL_REGISTER, 8'h80);
    d = 8'($random(seed));
    wr(IDX_SERIAL_DATA_BUFFER, d);
    u_peer.grab(10, 32, v);
    check(v[9:0], {2'b10, d});
    end_of_test();
  end
endmodule
